// >>> sac_params.svh
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
// register offsets
`define SAC_SYS_CTRL_OFS      8'h80
`define SAC_CARD_CTRL_OFS     8'h91
// field positions
`define SAC_RING_OSC_EN_BIT   27
`define SAC_VIDEO_EN_BIT      6
`define SAC_PWM_ROUTE_BIT     2
`define SAC_SPKR_EN_BIT       1
// reset values
`define SAC_SYS_CTRL_RST      32'h0000_0000
`define SAC_CARD_CTRL_RST     8'h00
// timing
`define SAC_CLK_HZ            10000000
`define SAC_LED_MS            64
`define SAC_LED_CYCLES        ((`SAC_CLK_HZ / 1000) * `SAC_LED_MS)
`define SAC_RING_HZ           16000
`define SAC_RING_HALF         ((`SAC_CLK_HZ / `SAC_RING_HZ) / 2)
`endif

// >>> sac_pkg.sv
package sac_pkg;
  typedef logic [25:0] sac_addr_t;
  // card side activity and audio pins, synchronised
  typedef struct packed {
    logic card_in;
    logic powered;
    logic in_reset;
    logic is_cardbus;
    logic io_mode;
    logic ready_irq_n;
    logic frame_n;
    logic irdy_n;
    logic req_n;
    logic audio;
  } sac_card_s;
  // power management inputs
  typedef struct packed {
    logic suspend;
    logic clk_stop;
    logic d1;
    logic d2;
  } sac_pm_s;
  typedef enum logic [0:0] {
    SAC_LED_IDLE = 1'b0,
    SAC_LED_ON   = 1'b1
  } sac_led_e;
endpackage

// >>> sac_socket_aux.sv
`timescale 1ns/100ps
// Overview of operation
// - card control bit 6 enables video passthrough per socket function
// - passthrough floats card address outputs 25 down to 4
// - address bits 3 down to 0 stay driven during passthrough
// - video source select output is low while passthrough enabled
// - video active output is high while passthrough enabled
// - system control bit 27 enables 16 kHz ring clock, off by default
// - ring clock allows socket power down and card interrogation without bus clock
// - 16-bit card in I/O mode uses battery detect 2 as speaker input
// - speaker output comes from SPKR or CAUDIO per card type
// - speaker output driven only while card control bit 1 set
// - card control bit 2 routes CardBus PWM audio to PWM output
// - activity LED pulses high for 64 ms per activity
// - LED driven low whenever not pulsing
// - activity counted only with card inserted, powered, not in reset
// - 16-bit card: low READY/IREQ counts as activity
// - CardBus: CFRAME, CIRDY or CREQ asserted counts as activity
// - LED forced off in suspend, clock stop, D1 or D2
// - new activity restarts 64 ms count, LED stays high
`include "sac_params.svh"
module sac_socket_aux (
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_I,
  input  wire logic              REG_WR_I,
  input  wire logic [7:0]        REG_ADDR_I,
  input  wire logic [31:0]       REG_WDATA_I,
  input  wire logic [3:0]        REG_BE_I,
  output logic      [31:0]       REG_RDATA_O,
  input  wire logic              REG_RD_I,
  input  wire sac_pkg::sac_addr_t CARD_ADDR_I,
  input  wire sac_pkg::sac_card_s CARD_I,
  input  wire sac_pkg::sac_pm_s  PM_I,
  output sac_pkg::sac_addr_t     CARD_ADDR_O,
  output logic      [25:0]       CARD_ADDR_OE_O,
  output logic                   VIDEO_SOURCE_SELECT_N_O,
  output logic                   VIDEO_PASSTHRU_ACTIVE_O,
  output logic                   SPEAKER_O,
  output logic                   PWM_AUDIO_O,
  output logic                   SOCKET_ACTIVITY_LED_O,
  output logic                   RING_CLK_O
);
  import sac_pkg::*;

  localparam int unsigned LED_CNT  = `SAC_LED_CYCLES;
  localparam int unsigned RING_CNT = `SAC_RING_HALF;

  logic [31:0] sys_ctrl_reg;
  logic [7:0]  card_ctrl_reg;
  sac_card_s   card_reg;
  sac_pm_s     pm_reg;
  sac_led_e    led_state_reg;
  sac_led_e    led_state_next;
  logic [19:0] led_cnt_reg;
  logic [19:0] led_cnt_next;
  logic [9:0]  ring_cnt_reg;
  logic [9:0]  ring_cnt_next;
  logic        ring_wrap;
  logic        sys_hit;
  logic        card_hit;
  logic        sys_wr;
  logic        card_wr;
  logic        video_en;
  logic        spkr_en;
  logic        pwm_route;
  logic        ring_en;
  logic        socket_live;
  logic        pc16_act;
  logic        cardbus_act;
  logic        activity;
  logic        led_block;
  logic        led_start;
  logic        spkr_src;
  logic        pwm_src;

  // pulse reload, counted down to zero
  localparam logic [19:0] LED_RELOAD = 20'(LED_CNT - 1);
  // last divider count before the ring clock toggles
  localparam logic [9:0]  RING_LAST  = 10'(RING_CNT - 1);

  // control fields of the two registers
  assign video_en  = card_ctrl_reg[`SAC_VIDEO_EN_BIT];
  assign spkr_en   = card_ctrl_reg[`SAC_SPKR_EN_BIT];
  assign pwm_route = card_ctrl_reg[`SAC_PWM_ROUTE_BIT];
  assign ring_en   = sys_ctrl_reg[`SAC_RING_OSC_EN_BIT];

  // register address decode
  assign sys_hit  = (REG_ADDR_I == `SAC_SYS_CTRL_OFS);
  assign card_hit = (REG_ADDR_I == `SAC_CARD_CTRL_OFS);
  assign sys_wr   = REG_WR_I & sys_hit;
  assign card_wr  = REG_WR_I & card_hit & REG_BE_I[0];

  // system control register, one byte lane per enable
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sys_ctrl_reg <= `SAC_SYS_CTRL_RST;
    end else if (sys_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (REG_BE_I[i]) begin
          sys_ctrl_reg[i*8 +: 8] <= REG_WDATA_I[i*8 +: 8];
        end
      end
    end
  end

  // card control register, single byte lane
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      card_ctrl_reg <= `SAC_CARD_CTRL_RST;
    end else if (card_wr) begin
      card_ctrl_reg <= REG_WDATA_I[7:0];
    end
  end

  // register read data, unmapped reads zero
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (REG_RD_I) begin
      if (sys_hit) begin
        REG_RDATA_O <= sys_ctrl_reg;
      end else if (card_hit) begin
        REG_RDATA_O <= {24'h00_0000, card_ctrl_reg};
      end else begin
        REG_RDATA_O <= 32'h0000_0000;
      end
    end
  end

  // card pins pass two flip-flops before any logic
  sac_sync2 #(
    .WIDTH ($bits(sac_card_s))
  ) sac_sync2_card_inst (
    .clk_i (REF_CLK_I),
    .rst_i (RST_I),
    .d_i   (CARD_I),
    .q_o   (card_reg)
  );

  // power management pins, same two-stage path
  sac_sync2 #(
    .WIDTH ($bits(sac_pm_s))
  ) sac_sync2_pm_inst (
    .clk_i (REF_CLK_I),
    .rst_i (RST_I),
    .d_i   (PM_I),
    .q_o   (pm_reg)
  );

  // address copy toward the socket
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CARD_ADDR_O <= '0;
    end else begin
      CARD_ADDR_O <= CARD_ADDR_I;
    end
  end

  // upper lines float during passthrough, low nibble always driven
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CARD_ADDR_OE_O <= 26'h3FF_FFFF;
    end else begin
      CARD_ADDR_OE_O[25:4] <= {22{~video_en}};
      CARD_ADDR_OE_O[3:0]  <= 4'hF;
    end
  end

  // active-low enable for external video bus drivers
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      VIDEO_SOURCE_SELECT_N_O <= 1'b1;
    end else begin
      VIDEO_SOURCE_SELECT_N_O <= ~video_en;
    end
  end

  // passthrough status, high while enabled
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      VIDEO_PASSTHRU_ACTIVE_O <= 1'b0;
    end else begin
      VIDEO_PASSTHRU_ACTIVE_O <= video_en;
    end
  end

  // speaker source: SPKR on 16-bit I/O cards, CAUDIO on CardBus
  always_comb begin
    spkr_src = 1'b0;
    if (card_reg.is_cardbus) begin
      spkr_src = card_reg.audio;
    end else if (card_reg.io_mode) begin
      spkr_src = card_reg.audio;
    end
  end

  // pwm audio exists only on CardBus cards
  assign pwm_src = card_reg.is_cardbus & card_reg.audio;

  // speaker output gated by its enable
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SPEAKER_O <= 1'b0;
    end else begin
      SPEAKER_O <= spkr_en & spkr_src;
    end
  end

  // pwm output only when routed
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PWM_AUDIO_O <= 1'b0;
    end else begin
      PWM_AUDIO_O <= pwm_route & pwm_src;
    end
  end

  // divider wraps after half a ring clock period
  assign ring_wrap = (ring_cnt_reg == RING_LAST);

  // divider next count, held at zero while disabled
  always_comb begin
    ring_cnt_next = ring_cnt_reg + 10'h001;
    if (!ring_en || ring_wrap) begin
      ring_cnt_next = 10'h000;
    end
  end

  // divider count register
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ring_cnt_reg <= '0;
    end else begin
      ring_cnt_reg <= ring_cnt_next;
    end
  end

  // ring clock output, low while disabled
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RING_CLK_O <= 1'b0;
    end else if (!ring_en) begin
      RING_CLK_O <= 1'b0;
    end else if (ring_wrap) begin
      RING_CLK_O <= ~RING_CLK_O;
    end
  end

  // socket must be inserted, powered and out of reset
  assign socket_live = card_reg.card_in & card_reg.powered & ~card_reg.in_reset;

  // 16-bit cards: low ready or interrupt line is activity
  assign pc16_act = ~card_reg.ready_irq_n;

  // CardBus cards: frame, initiator ready or request asserted
  assign cardbus_act = ~card_reg.frame_n | ~card_reg.irdy_n | ~card_reg.req_n;

  // gated activity for the present card type
  assign activity = socket_live & (card_reg.is_cardbus ? cardbus_act : pc16_act);

  // suspend, clock stop, D1 and D2 all cut the led off
  assign led_block = pm_reg.suspend | pm_reg.clk_stop | pm_reg.d1 | pm_reg.d2;

  // a pulse may only start while not blocked
  assign led_start = activity & ~led_block;

  // led pulse state and counter next values
  always_comb begin
    led_state_next = led_state_reg;
    led_cnt_next   = led_cnt_reg;
    unique case (led_state_reg)
      SAC_LED_IDLE: begin
        if (led_start) begin
          led_state_next = SAC_LED_ON;
          led_cnt_next   = LED_RELOAD;
        end
      end
      SAC_LED_ON: begin
        if (led_block) begin
          led_state_next = SAC_LED_IDLE;
          led_cnt_next   = '0;
        end else if (activity) begin
          led_cnt_next   = LED_RELOAD;
        end else if (led_cnt_reg == 20'h0_0000) begin
          led_state_next = SAC_LED_IDLE;
        end else begin
          led_cnt_next   = led_cnt_reg - 20'h0_0001;
        end
      end
    endcase
  end

  // led pulse state
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      led_state_reg <= SAC_LED_IDLE;
    end else begin
      led_state_reg <= led_state_next;
    end
  end

  // led pulse counter
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      led_cnt_reg <= '0;
    end else begin
      led_cnt_reg <= led_cnt_next;
    end
  end

  // led output, driven low whenever idle
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SOCKET_ACTIVITY_LED_O <= 1'b0;
    end else begin
      SOCKET_ACTIVITY_LED_O <= (led_state_next == SAC_LED_ON);
    end
  end
endmodule

// two flip-flop synchroniser for pin inputs
module sac_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  // first stage, read only by the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
    end else begin
      meta_reg <= d_i;
    end
  end

  // second stage, the only one logic may read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      q_o <= meta_reg;
    end
  end
endmodule

// >>> sac_socket_aux_sva.sv
`timescale 1ns/100ps
`include "sac_params.svh"
module sac_socket_aux_sva
  import sac_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        REG_WR_I,
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [3:0]  REG_BE_I,
  input wire sac_card_s   CARD_I,
  input wire sac_pm_s     PM_I,
  input wire logic [25:0] CARD_ADDR_OE_O,
  input wire logic        VIDEO_SOURCE_SELECT_N_O,
  input wire logic        VIDEO_PASSTHRU_ACTIVE_O,
  input wire logic        SPEAKER_O,
  input wire logic        PWM_AUDIO_O,
  input wire logic        SOCKET_ACTIVITY_LED_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // any power block, and any gated socket activity
  wire logic blk = |PM_I;
  wire logic act = CARD_I.card_in && CARD_I.powered && !CARD_I.in_reset &&
    (CARD_I.is_cardbus ? !(CARD_I.frame_n && CARD_I.irdy_n && CARD_I.req_n)
                       : !CARD_I.ready_irq_n);
  sequence ctrl_wr;
    REG_WR_I && REG_ADDR_I == `SAC_CARD_CTRL_OFS && REG_BE_I[0];
  endsequence
  sequence settle;
    !REG_WR_I [*3];
  endsequence
  AST_VIDEO_EN: assert property (ctrl_wr ##1 settle |->
    VIDEO_PASSTHRU_ACTIVE_O == $past(REG_WDATA_I[6], 3)) else $error("video enable stale");
  AST_ADDR_FLOAT: assert property (CARD_ADDR_OE_O[25:4] == {22{!VIDEO_PASSTHRU_ACTIVE_O}})
    else $error("upper address drive wrong");
  AST_ADDR_LOW: assert property (CARD_ADDR_OE_O[3:0] == 4'hF)
    else $error("low address not driven");
  AST_SELECT_POL: assert property (VIDEO_SOURCE_SELECT_N_O != VIDEO_PASSTHRU_ACTIVE_O)
    else $error("select and status disagree");
  AST_SPKR_SRC: assert property (SPEAKER_O |-> $past(CARD_I.audio, 3) &&
    ($past(CARD_I.is_cardbus, 3) || $past(CARD_I.io_mode, 3))) else $error("speaker source");
  AST_PWM_SRC: assert property (PWM_AUDIO_O |->
    $past(CARD_I.audio, 3) && $past(CARD_I.is_cardbus, 3)) else $error("pwm source");
  AST_LED_BLOCK: assert property (blk [*4] |=> !SOCKET_ACTIVITY_LED_O)
    else $error("led not blocked");
  AST_LED_CAUSE: assert property ($rose(SOCKET_ACTIVITY_LED_O) |->
    $past(act, 3) && !$past(blk, 3)) else $error("led without activity");
endmodule
bind sac_socket_aux sac_socket_aux_sva sac_socket_aux_sva_inst (.*);

// >>> sac_card_model.sv
`timescale 1ns/100ps
module sac_card_model
  import sac_pkg::*;
(
  input  wire logic       cardbus_i,
  input  wire logic       ok_i,
  input  wire logic       io_i,
  input  wire logic       busy_i,
  input  wire logic       tone_i,
  input  wire logic [1:0] sig_i,
  output sac_card_s       card_o
);
  // strobes rest high on pullups, low only during traffic
  assign card_o = {ok_i, ok_i, !ok_i, cardbus_i, io_i, !(busy_i && !cardbus_i),
                    !(busy_i && cardbus_i && sig_i == 2'd0),
                    !(busy_i && cardbus_i && sig_i == 2'd1),
                    !(busy_i && cardbus_i && sig_i == 2'd2), tone_i};
endmodule

// >>> sac_socket_aux_tb.sv
`timescale 1ns/100ps
`include "sac_params.svh"
module sac_socket_aux_tb;
  import sac_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, cb = 0, ok = 0, io = 0, busy = 0, tone = 0;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0, rdata, rng = 22598;
  logic [3:0]  be = 0;
  logic [1:0]  sig = 0;
  logic [25:0] oe;
  sac_addr_t   ain = 0, aout;
  sac_pm_s     pm = '0;
  sac_card_s   card;
  logic        sel_n, act, spk, pwm, led, ring;
  int          bad_count = 0, tests_run = 0, card_q = 0, sys_q = 0, t0;
  // reference clock, 100 ns period
  always #50 clk = ~clk;
  sac_socket_aux sac_socket_aux_inst (.REF_CLK_I(clk), .RST_I(rst), .REG_WR_I(wr),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_BE_I(be), .REG_RDATA_O(rdata),
    .REG_RD_I(rd), .CARD_ADDR_I(ain), .CARD_I(card), .PM_I(pm), .CARD_ADDR_O(aout),
    .CARD_ADDR_OE_O(oe), .VIDEO_SOURCE_SELECT_N_O(sel_n), .VIDEO_PASSTHRU_ACTIVE_O(act),
    .SPEAKER_O(spk), .PWM_AUDIO_O(pwm), .SOCKET_ACTIVITY_LED_O(led), .RING_CLK_O(ring));
  sac_card_model sac_card_model_inst (.cardbus_i(cb), .ok_i(ok), .io_i(io),
    .busy_i(busy), .tone_i(tone), .sig_i(sig), .card_o(card));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic close_out;
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // write and update the register model per byte lane
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    addr = a;
    wdata = d;
    be = b;
    wr = 1;
    if (a == `SAC_CARD_CTRL_OFS && b[0]) card_q = d[7:0];
    for (int i = 0; i < 4; i++) if (a == `SAC_SYS_CTRL_OFS && b[i]) sys_q[8*i+:8] = d[8*i+:8];
    cyc(1);
    wr = 0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    addr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    cyc(1);
    check(rdata, exp);
  endtask
  task automatic pulse_busy;
    busy = 1;
    cyc(1);
    busy = 0;
    cyc(4);
  endtask
  // watchdog
  initial begin
    #(30000 * 100);
    bad_count++;
    close_out;
  end
  // main sequence
  initial begin
    cyc(2);
    rst = 0;
    rreg(`SAC_SYS_CTRL_OFS, 0);
    check({led, spk, pwm, ring, sel_n, act}, 6'h02);
    repeat (8) begin
      rng = xs(rng);
      ain = rng[25:0];
      wreg(`SAC_CARD_CTRL_OFS, rng, rng[31:28]);
      cyc(3);
      check({sel_n, act, oe}, {!card_q[6], card_q[6], {22{!card_q[6]}}, 4'hF});
      check(aout, ain);
      rreg(`SAC_CARD_CTRL_OFS, card_q);
    end
    wreg(8'h84, 32'hFFFF_FFFF, 4'hF);
    rreg(8'h84, 0);
    wreg(`SAC_CARD_CTRL_OFS, 32'h06, 4'h1);
    for (int k = 0; k < 8; k++) begin
      {cb, io, tone} = k[2:0];
      cyc(4);
      check({spk, pwm}, {tone & (cb | io), tone & cb});
    end
    wreg(`SAC_CARD_CTRL_OFS, 32'h00, 4'h1);
    cyc(4);
    check({spk, pwm}, 0);
    pulse_busy;
    check(led, 0);
    ok = 1;
    for (int k = 0; k < 4; k++) begin
      rst = 1;
      cyc(1);
      rst = 0;
      card_q = 0;
      check(led, 0);
      cb = k != 0;
      sig = k[1:0] - 2'd1;
      pulse_busy;
      check(led, 1);
    end
    for (int k = 0; k < 4; k++) begin
      cyc(1500);
      pulse_busy;
      check(led, 1);
      pm = 4'h8 >> k;
      pulse_busy;
      check(led, 0);
      pm = '0;
    end
    wreg(`SAC_SYS_CTRL_OFS, 32'h0800_0000, 4'h8);
    rreg(`SAC_SYS_CTRL_OFS, sys_q);
    @(posedge ring);
    t0 = $time;
    @(posedge ring);
    check(($time - t0) / 100, 2 * `SAC_RING_HALF);
    cyc(1);
    wreg(`SAC_SYS_CTRL_OFS, 0, 4'hF);
    cyc(3);
    check(ring, 0);
    close_out;
  end
endmodule
